/* dv/drive_terminal_io_conditioning_bench.sv */
`timescale 1ns/1ps
module drive_terminal_io_conditioning_bench;
   import io_cond_pkg::*;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, rerr, coil;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] sw, din, dstate;
   logic [15:0] ai1, ai2, ai3;
   logic [5:0] st;
   logic [2:0][15:0] cval;
   logic [2:0] bmin;
   logic mux_o, relay_o, ext_r, oc1, ext_o;
   logic [5:0] fdef [5] = '{6'h00, 6'h02, 6'h00, 6'h01, 6'h04};
   int mismatches, checks;

   field_wiring i_field_wiring (.switch_closed(sw), .main_relay(relay_o),
      .digital_input(din), .relay_coil(coil));
   drive_terminal_io_conditioning #(.TICK_CYCLES(4)) i_drive_terminal_io_conditioning (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .digital_input(din), .analog_input_1(ai1), .analog_input_2(ai2),
      .analog_input_3(ai3), .drive_running(st[5]), .fault_stop(st[4]),
      .frequency_level_detect_1(st[3]), .frequency_reached(st[2]),
      .output_freq_zero(st[1]), .overload_prewarn(st[0]),
      .digital_input_state(dstate), .curve_value(cval), .below_min(bmin),
      .multiplexed_pulse_switch_output(mux_o), .main_relay(relay_o),
      .extension_relay(ext_r), .open_collector_output_1(oc1),
      .extension_digital_output(ext_o));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic end_of_test;
      if (mismatches == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // Pre-edge values: what the slave showed at this rising edge
      @(posedge clk);
      while (n < 20 && pready !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) begin
         mismatches++;
         end_of_test();
      end
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic t_defaults;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, OFS_FUNC0 + 12'(4 * i), 32'h0);
         chk("function code", 32'(fdef[i]), rd);
      end
      apb(1'b0, OFS_LEVEL_A, 32'h0);
      chk("level a", 32'h0, rd);
      apb(1'b0, OFS_LEVEL_B, 32'h0);
      chk("level b", 32'h0, rd);
      apb(1'b0, OFS_AI2_TYPE, 32'h0);
      chk("analog2 type", 32'h0, rd);
      apb(1'b0, OFS_MUX_MODE, 32'h0);
      chk("mux mode", 32'h0, rd);
      apb(1'b0, 12'h100, 32'h0);
      chk("unmapped error", 32'h1, 32'(rerr));
   endtask

   task automatic t_levels;
      sw <= 10'h155;
      settle(4);
      chk("state level 0", 32'h155, 32'(dstate));
      apb(1'b1, OFS_LEVEL_A, 32'h1F);
      apb(1'b1, OFS_LEVEL_B, 32'h1F);
      settle(4);
      chk("state level 1", 32'h2AA, 32'(dstate));
      apb(1'b1, OFS_LEVEL_A, 32'h05);
      apb(1'b1, OFS_LEVEL_B, 32'h00);
      settle(4);
      chk("state mixed", 32'h150, 32'(dstate));
      apb(1'b1, OFS_LEVEL_A, 32'h00);
      sw <= 10'h000;
      settle(6);
   endtask

   task automatic t_delay;
      int n;
      apb(1'b1, OFS_DELAY0, 32'h3);
      sw <= 10'h009;
      settle(5);
      chk("undelayed input 4", 32'h1, 32'(dstate[3]));
      chk("delayed input 1 early", 32'h0, 32'(dstate[0]));
      n = 5;
      while (n < 40 && dstate[0] !== 1'b1) begin
         settle(1);
         n++;
      end
      // Three edges to the filter, three steps of four, one to the output
      chk("delay edges", 32'd16, 32'(n));
      @(posedge clk);
      sw <= 10'h000;
      apb(1'b1, OFS_DELAY0, 32'h0);
      settle(20);
   endtask

   task automatic t_outputs;
      logic e;
      apb(1'b1, OFS_MUX_MODE, 32'h1);
      for (int c = 0; c < 8; c++) begin
         for (int i = 0; i < 5; i++) apb(1'b1, OFS_FUNC0 + 12'(4 * i), 32'(c));
         for (int p = 0; p < 64; p++) begin
            @(posedge clk);
            st <= 6'(p);
            settle(3);
            case (c)
               1: e = st[5];
               2: e = st[4];
               3: e = st[3];
               4: e = st[2];
               5: e = st[5] & st[1];
               6: e = st[0];
               default: e = 1'b0;
            endcase
            chk("outputs", 32'({5{e}}), 32'({mux_o, coil, ext_r, oc1, ext_o}));
         end
      end
   endtask

   task automatic t_pulse;
      int n;
      logic last;
      apb(1'b1, OFS_MUX_MODE, 32'h0);
      apb(1'b1, OFS_PULSE_HALF, 32'h64);
      for (int k = 0; k < 2; k++) begin
         last = mux_o;
         n = 0;
         while (n < 600 && mux_o === last) begin
            settle(1);
            n++;
         end
      end
      chk("pulse half period", 32'd250, 32'(n));
   endtask

   task automatic t_analog;
      apb(1'b1, OFS_CURVE0, 32'h1234_0064);
      apb(1'b1, OFS_CURVE0 + 12'h4, 32'h0ABC_0064);
      apb(1'b1, OFS_BELOW_MIN, 32'h2);
      ai1 <= 16'h0032;
      ai2 <= 16'h0032;
      ai3 <= 16'h0010;
      settle(3);
      chk("below flags", 32'h3, 32'(bmin));
      chk("ch1 min setting", 32'h1234, 32'(cval[0]));
      chk("ch2 zero", 32'h0, 32'(cval[1]));
      chk("ch3 pass", 32'h0010, 32'(cval[2]));
      apb(1'b1, OFS_AI2_TYPE, 32'h1);
      ai2 <= 16'h00C8;
      settle(3);
      chk("ch2 current", 32'h0064, 32'(cval[1]));
      @(posedge clk);
      ai2 <= 16'h00C6;
      settle(3);
      chk("ch2 current below", 32'h0, 32'(cval[1]));
   endtask

   initial begin
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {sw, ai1, ai2, ai3, st} = '0;
      mismatches = 0;
      checks = 0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_defaults();
      t_levels();
      t_delay();
      t_analog();
      t_outputs();
      t_pulse();
      end_of_test();
   end
endmodule // drive_terminal_io_conditioning_bench

/* dv/field_wiring.sv */
`timescale 1ns/1ps
module field_wiring (
   input wire logic [9:0] switch_closed,
   input wire logic main_relay,
   output logic [9:0] digital_input,
   output logic relay_coil
);
   // Contacts are ideal; no scenario drives contact bounce into the input filter
   assign digital_input = switch_closed;
   assign relay_coil = main_relay;
endmodule // field_wiring

/* inc/delay_if.sv */
`timescale 1ns/1ps
interface delay_if;
   logic level;
   logic [15:0] delay;
   logic state;
   modport src (output level, output delay, input state);
   modport filt (input level, input delay, output state);
endinterface

/* inc/io_cond_pkg.sv */
package io_cond_pkg;
   // Clock and time bases
   localparam int CLK_HZ = 25_000_000;
   localparam int DELAY_STEP_MS = 100;
   localparam int DELAY_TICK_CYCLES = CLK_HZ / 1000 * DELAY_STEP_MS;
   localparam logic [15:0] DELAY_MAX_STEPS = 16'h8CA0;
   localparam int PULSE_MAX_HZ = 50_000;
   localparam logic [15:0] PULSE_MIN_HALF =
      16'((CLK_HZ + 2 * PULSE_MAX_HZ - 1) / (2 * PULSE_MAX_HZ));

   // Register byte offsets
   localparam logic [11:0] OFS_BELOW_MIN = 12'h000;
   localparam logic [11:0] OFS_DELAY0 = 12'h004;
   localparam logic [11:0] OFS_LEVEL_A = 12'h010;
   localparam logic [11:0] OFS_LEVEL_B = 12'h014;
   localparam logic [11:0] OFS_AI2_TYPE = 12'h018;
   localparam logic [11:0] OFS_MUX_MODE = 12'h01C;
   localparam logic [11:0] OFS_FUNC0 = 12'h020;
   localparam logic [11:0] OFS_CURVE0 = 12'h034;
   localparam logic [11:0] OFS_PULSE_HALF = 12'h040;
   localparam logic [11:0] OFS_IN_STATE = 12'h044;
   localparam logic [11:0] OFS_VALUE0 = 12'h048;

   // Output function codes
   typedef logic [5:0] func_t;
   localparam func_t FN_NONE = 6'h00;
   localparam func_t FN_RUNNING = 6'h01;
   localparam func_t FN_FAULT = 6'h02;
   localparam func_t FN_LEVEL_DET1 = 6'h03;
   localparam func_t FN_REACHED = 6'h04;
   localparam func_t FN_ZERO_RUN = 6'h05;
   localparam func_t FN_PREWARN = 6'h06;

   // Values after reset
   localparam logic [2:0] RST_BELOW_MIN = 3'h0;
   localparam logic [4:0] RST_LEVEL = 5'h00;
   localparam logic RST_AI2_TYPE = 1'b0;
   localparam logic RST_MUX_MODE = 1'b0;
   localparam logic [15:0] RST_DELAY = 16'h0000;
   localparam logic [15:0] RST_PULSE_HALF = 16'h0000;
   localparam logic [31:0] RST_CURVE = 32'h0000_0000;
   localparam func_t FUNC_RST [5] = '{FN_NONE, FN_FAULT, FN_NONE, FN_RUNNING, FN_REACHED};
endpackage

/* src/drive_terminal_io_conditioning.sv */
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
// What this block does
// (RQ1) Analog below minimum with digit 0 gives the channel's minimum-point setting.
// (RQ2) Analog below minimum with digit 1 gives 0.0 percent.
// (RQ3) Inputs with delay act on a change only after 0.0 to 3600.0 s.
// (RQ4) Only inputs one to three are delayed; the rest act at once.
// (RQ5) Ten one-bit active-level selects, five per selector, both reset to zero.
// (RQ6) Level 0: closed to common return is asserted, open is deasserted.
// (RQ7) Level 1: closed to common return is deasserted.
// (RQ8) Level 1: open from common return is asserted.
// (RQ9) Analog input two reads voltage at 0, current at 1, reset 0.
// (RQ10) In current mode 1 mA counts as 0.5 V.
// (RQ11) Multiplexed output: pulse output at mode 0, switch output at mode 1.
// (RQ12) Pulse output never exceeds 50 kHz.
// (RQ13) Five output function selectors with reset codes 0, 2, 0, 1, 4.
// (RQ14) Code 0 never asserts the output.
// (RQ15) Code 1 asserts while running, also at zero output frequency.
// (RQ16) Code 2 asserts when stopped by a fault.
// (RQ17) Codes 3 and 4 follow level detect one and frequency reached.
// (RQ18) Code 5 asserts running at zero frequency, off when stopped.
// (RQ19) Code 6 asserts on motor overload pre-warning.
module drive_terminal_io_conditioning #(
   parameter int TICK_CYCLES = io_cond_pkg::DELAY_TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [9:0] digital_input,
   input wire logic [15:0] analog_input_1,
   input wire logic [15:0] analog_input_2,
   input wire logic [15:0] analog_input_3,
   input wire logic drive_running,
   input wire logic fault_stop,
   input wire logic frequency_level_detect_1,
   input wire logic frequency_reached,
   input wire logic output_freq_zero,
   input wire logic overload_prewarn,
   output logic [9:0] digital_input_state,
   output logic [2:0][15:0] curve_value,
   output logic [2:0] below_min,
   output logic multiplexed_pulse_switch_output,
   output logic main_relay,
   output logic extension_relay,
   output logic open_collector_output_1,
   output logic extension_digital_output
);
   import io_cond_pkg::*;

   logic [2:0] below_min_r;
   logic [15:0] delay_r [3];
   logic [4:0] level_a_r;
   logic [4:0] level_b_r;
   logic ai2_type_r;
   logic mux_mode_r;
   func_t func_r [5];
   logic [31:0] curve_r [3];
   logic [15:0] pulse_half_r;
   logic [9:0] sync1_r;
   logic [9:0] sync2_r;
   logic [9:0] lvl_c;
   logic [2:0] filt_state;
   logic [15:0] ain [3];
   logic [15:0] conv_c [3];
   logic [2:0] below_c;
   logic [5:0] drv_c;
   logic [15:0] pcnt_r;
   logic pulse_r;
   logic [31:0] rd_c;
   logic hit_c;
   logic wr_en;
   logic [15:0] pulse_w;
   logic [15:0] delay_w;

   function automatic logic [11:0] slot(input logic [11:0] base, input int idx);
      slot = base + 12'(4 * idx);
   endfunction

   function automatic logic func_out(input func_t code, input logic [5:0] st);
      case (code)
         FN_NONE: func_out = 1'b0; // RQ14
         FN_RUNNING: func_out = st[0]; // RQ15
         FN_FAULT: func_out = st[1]; // RQ16
         FN_LEVEL_DET1: func_out = st[2]; // RQ17
         FN_REACHED: func_out = st[3]; // RQ17
         FN_ZERO_RUN: func_out = st[0] & st[4]; // RQ18
         FN_PREWARN: func_out = st[5]; // RQ19
         default: func_out = 1'b0;
      endcase
   endfunction

   assign ain[0] = analog_input_1;
   assign ain[1] = analog_input_2;
   assign ain[2] = analog_input_3;
   assign drv_c = {overload_prewarn, output_freq_zero, frequency_reached,
                   frequency_level_detect_1, fault_stop, drive_running};

   // APB slave: one wait-free access phase, data registered at setup
   assign wr_en = psel & penable & pready & pwrite;

   always_comb begin
      rd_c = 32'h0000_0000;
      hit_c = paddr[1:0] == 2'h0 &&
              (paddr == OFS_BELOW_MIN || paddr == OFS_LEVEL_A ||
               paddr == OFS_LEVEL_B || paddr == OFS_AI2_TYPE ||
               paddr == OFS_MUX_MODE || paddr == OFS_PULSE_HALF ||
               paddr == OFS_IN_STATE);
      case (paddr)
         OFS_BELOW_MIN: rd_c = {29'h0, below_min_r};
         OFS_LEVEL_A: rd_c = {27'h0, level_a_r};
         OFS_LEVEL_B: rd_c = {27'h0, level_b_r};
         OFS_AI2_TYPE: rd_c = {31'h0, ai2_type_r};
         OFS_MUX_MODE: rd_c = {31'h0, mux_mode_r};
         OFS_PULSE_HALF: rd_c = {16'h0, pulse_half_r};
         OFS_IN_STATE: rd_c = {22'h0, digital_input_state};
         default: rd_c = 32'h0000_0000;
      endcase
      for (int i = 0; i < 3; i++) begin
         if (paddr == slot(OFS_DELAY0, i)) begin
            rd_c = {16'h0, delay_r[i]};
            hit_c = 1'b1;
         end
         if (paddr == slot(OFS_CURVE0, i)) begin
            rd_c = curve_r[i];
            hit_c = 1'b1;
         end
         if (paddr == slot(OFS_VALUE0, i)) begin
            rd_c = {{16{curve_value[i][15]}}, curve_value[i]};
            hit_c = 1'b1;
         end
      end
      for (int i = 0; i < 5; i++) begin
         if (paddr == slot(OFS_FUNC0, i)) begin
            rd_c = {26'h0, func_r[i]};
            hit_c = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         prdata <= rd_c;
         pslverr <= ~hit_c;
      end else if (pready) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Out-of-range values are clamped rather than refused
   always_comb begin
      pulse_w = pwdata[15:0];
      if (pulse_w != 16'h0000 && pulse_w < PULSE_MIN_HALF) begin
         pulse_w = PULSE_MIN_HALF; // RQ12
      end
      delay_w = pwdata[15:0];
      if (delay_w > DELAY_MAX_STEPS) begin
         delay_w = DELAY_MAX_STEPS; // RQ3
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         below_min_r <= RST_BELOW_MIN;
         level_a_r <= RST_LEVEL; // RQ5
         level_b_r <= RST_LEVEL; // RQ5
         ai2_type_r <= RST_AI2_TYPE; // RQ9
         mux_mode_r <= RST_MUX_MODE; // RQ11
         pulse_half_r <= RST_PULSE_HALF;
      end else if (wr_en) begin
         case (paddr)
            OFS_BELOW_MIN: below_min_r <= pwdata[2:0];
            OFS_LEVEL_A: level_a_r <= pwdata[4:0];
            OFS_LEVEL_B: level_b_r <= pwdata[4:0];
            OFS_AI2_TYPE: ai2_type_r <= pwdata[0];
            OFS_MUX_MODE: mux_mode_r <= pwdata[0];
            OFS_PULSE_HALF: pulse_half_r <= pulse_w;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 3; i++) begin
            delay_r[i] <= RST_DELAY;
            curve_r[i] <= RST_CURVE;
         end
      end else if (wr_en) begin
         for (int i = 0; i < 3; i++) begin
            if (paddr == slot(OFS_DELAY0, i)) begin
               delay_r[i] <= delay_w;
            end
            if (paddr == slot(OFS_CURVE0, i)) begin
               curve_r[i] <= pwdata;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 5; i++) begin
            func_r[i] <= FUNC_RST[i]; // RQ13
         end
      end else if (wr_en) begin
         for (int i = 0; i < 5; i++) begin
            if (paddr == slot(OFS_FUNC0, i)) begin
               func_r[i] <= pwdata[5:0];
            end
         end
      end
   end

   // Digital inputs: 1 on a pin means closed to the common return
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1_r <= 10'h000;
         sync2_r <= 10'h000;
      end else begin
         sync1_r <= digital_input;
         sync2_r <= sync1_r;
      end
   end

   assign lvl_c = sync2_r ^ {level_b_r, level_a_r}; // RQ6 RQ7 RQ8

   for (genvar g = 0; g < 3; g++) begin : g_dly
      delay_if dif ();
      assign dif.level = lvl_c[g];
      assign dif.delay = delay_r[g];
      assign filt_state[g] = dif.state;
      input_delay_filter #(
         .TICK_CYCLES(TICK_CYCLES)
      ) i_input_delay_filter (
         .clk(clk),
         .reset(reset),
         .dly(dif)
      );
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         digital_input_state <= 10'h000;
      end else begin
         digital_input_state <= {lvl_c[9:3], filt_state}; // RQ4
      end
   end

   // Analog: current codes halve to voltage codes; curve comes after this block
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         conv_c[i] = ain[i];
         if (i == 1 && ai2_type_r) begin
            conv_c[i] = {ain[i][15], ain[i][15:1]}; // RQ9 RQ10
         end
         below_c[i] = $signed(conv_c[i]) < $signed(curve_r[i][15:0]);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         curve_value <= '0;
         below_min <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            below_min[i] <= below_c[i];
            if (!below_c[i]) begin
               curve_value[i] <= conv_c[i];
            end else if (below_min_r[i]) begin
               curve_value[i] <= 16'h0000; // RQ2
            end else begin
               curve_value[i] <= curve_r[i][31:16]; // RQ1
            end
         end
      end
   end

   // Pulse generator; period comes from software, floor set by write clamp
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pcnt_r <= 16'h0000;
         pulse_r <= 1'b0;
      end else if (!mux_mode_r && pulse_half_r != 16'h0000) begin
         if (pcnt_r + 16'h0001 >= pulse_half_r) begin
            pcnt_r <= 16'h0000;
            pulse_r <= ~pulse_r; // RQ12
         end else begin
            pcnt_r <= pcnt_r + 16'h0001;
         end
      end else begin
         pcnt_r <= 16'h0000;
         pulse_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         multiplexed_pulse_switch_output <= 1'b0;
         main_relay <= 1'b0;
         extension_relay <= 1'b0;
         open_collector_output_1 <= 1'b0;
         extension_digital_output <= 1'b0;
      end else begin
         multiplexed_pulse_switch_output <=
            mux_mode_r ? func_out(func_r[0], drv_c) : pulse_r; // RQ11
         main_relay <= func_out(func_r[1], drv_c);
         extension_relay <= func_out(func_r[2], drv_c);
         open_collector_output_1 <= func_out(func_r[3], drv_c);
         extension_digital_output <= func_out(func_r[4], drv_c);
      end
   end

   // Helper logic for assertions
   logic pulse_q_r;
   logic [15:0] gap_r;
   logic min_set0;
   logic [15:0] ain2_half;
   logic pin_lvl3;
   logic pin_lvl9;
   logic fsel0;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pulse_q_r <= 1'b0;
         gap_r <= 16'h0000;
      end else begin
         pulse_q_r <= pulse_r;
         if (pulse_r != pulse_q_r) begin
            gap_r <= 16'h0000;
         end else if (gap_r != 16'hFFFF) begin
            gap_r <= gap_r + 16'h0001;
         end
      end
   end

   assign ain2_half = {analog_input_2[15], analog_input_2[15:1]};
   assign pin_lvl3 = digital_input[3] ^ level_a_r[3];
   assign pin_lvl9 = digital_input[9] ^ level_b_r[4];
   assign fsel0 = func_out(func_r[0], drv_c);
   assign min_set0 = below_c[0] & ~below_min_r[0];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   property p_below_setting;
      min_set0 |=> curve_value[0] == $past(curve_r[0]) >> 16;
   endproperty
   a_below_setting: assert property (p_below_setting) else $error("minimum setting not used"); // RQ1

   property p_below_zero;
      (below_c[2] && below_min_r[2]) |=> curve_value[2] == 16'h0000 && below_min[2];
   endproperty
   a_below_zero: assert property (p_below_zero) else $error("below minimum not zero"); // RQ2

   property p_current_scale;
      (ai2_type_r && !below_c[1]) |=> curve_value[1] == $past(ain2_half);
   endproperty
   a_current_scale: assert property (p_current_scale) else $error("current not halved"); // RQ10

   property p_level_a_fast;
      $stable(level_a_r)[*4] |-> digital_input_state[3] == $past(pin_lvl3, 3);
   endproperty
   a_level_a_fast: assert property (p_level_a_fast) else $error("input four level wrong"); // RQ4 RQ6 RQ8

   property p_level_b_fast;
      $stable(level_b_r)[*4] |-> digital_input_state[9] == $past(pin_lvl9, 3);
   endproperty
   a_level_b_fast: assert property (p_level_b_fast) else $error("input ten level wrong"); // RQ5 RQ7

   sequence s_switch_mode;
      mux_mode_r ##1 mux_mode_r;
   endsequence

   property p_switch_follow;
      s_switch_mode |-> multiplexed_pulse_switch_output == $past(fsel0);
   endproperty
   a_switch_follow: assert property (p_switch_follow) else $error("switch mode wrong"); // RQ11

   property p_pulse_rate;
      (pulse_r != pulse_q_r && $past(pulse_r) == pulse_q_r && pulse_r)
         |-> gap_r >= PULSE_MIN_HALF - 16'h0001;
   endproperty
   a_pulse_rate: assert property (p_pulse_rate) else $error("pulse too fast"); // RQ12

   property p_code_none;
      (func_r[1] == FN_NONE) |=> !main_relay;
   endproperty
   a_code_none: assert property (p_code_none) else $error("code 0 asserted"); // RQ14

   property p_code_running;
      (func_r[3] == FN_RUNNING) |=> open_collector_output_1 == $past(drive_running);
   endproperty
   a_code_running: assert property (p_code_running) else $error("running wrong"); // RQ15

   property p_code_fault;
      (func_r[1] == FN_FAULT && fault_stop) |=> main_relay;
   endproperty
   a_code_fault: assert property (p_code_fault) else $error("fault not shown"); // RQ16

   property p_code_zero_run;
      (func_r[4] == FN_ZERO_RUN && !drive_running) |=> !extension_digital_output;
   endproperty
   a_code_zero_run: assert property (p_code_zero_run) else $error("zero run at stop"); // RQ18
endmodule // drive_terminal_io_conditioning

/* src/input_delay_filter.sv */
`timescale 1ns/1ps
module input_delay_filter #(
   parameter int TICK_CYCLES = io_cond_pkg::DELAY_TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   delay_if.filt dly
);
   import io_cond_pkg::*;

   localparam int TW = $clog2(TICK_CYCLES + 1);

   typedef enum logic [1:0] {
      ST_STABLE = 2'b01,
      ST_PENDING = 2'b10
   } dstate_t;

   dstate_t st_r;
   logic [TW-1:0] sub_r;
   logic [15:0] cnt_r;
   logic state_r;

   assign dly.state = state_r;

   // Prescaler restarts on each change, so the delay is exact
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r <= ST_STABLE;
         sub_r <= '0;
         cnt_r <= 16'h0000;
         state_r <= 1'b0;
      end else begin
         case (st_r)
            ST_STABLE: begin
               if (dly.level != state_r) begin
                  if (dly.delay == 16'h0000) begin
                     state_r <= dly.level; // RQ3
                  end else begin
                     st_r <= ST_PENDING;
                     sub_r <= '0;
                     cnt_r <= 16'h0000;
                  end
               end
            end
            ST_PENDING: begin
               if (dly.level == state_r) begin
                  st_r <= ST_STABLE;
               end else if (sub_r == TW'(TICK_CYCLES - 1)) begin
                  sub_r <= '0;
                  if (cnt_r + 16'h0001 >= dly.delay) begin
                     state_r <= dly.level; // RQ3
                     st_r <= ST_STABLE;
                  end else begin
                     cnt_r <= cnt_r + 16'h0001;
                  end
               end else begin
                  sub_r <= sub_r + TW'(1);
               end
            end
            default: st_r <= ST_STABLE;
         endcase
      end
   end

   sequence s_change_req;
      st_r == ST_STABLE && dly.level != state_r && dly.delay != 16'h0000;
   endsequence

   property p_delay_hold;
      @(posedge clk) disable iff (reset) s_change_req |=> $stable(state_r);
   endproperty
   a_delay_hold: assert property (p_delay_hold) else $error("input changed without delay"); // RQ3
endmodule // input_delay_filter
